// File: rtl/csd_pkg.sv
// Constants, types and register map of the cut-off solenoid driver
package csd_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] A_PRES   = 8'h00;
    localparam logic [7:0] A_MODE   = 8'h04;
    localparam logic [7:0] A_PULL   = 8'h08;
    localparam logic [7:0] A_HOLD   = 8'h0C;
    localparam logic [7:0] A_PRELD  = 8'h10;
    localparam logic [7:0] A_TMO    = 8'h14;
    localparam logic [7:0] A_VTYPE  = 8'h18;
    localparam logic [7:0] A_STAT   = 8'h1C;

    // ----------------------------------------------------------------
    // Values, reset values and limits
    // ----------------------------------------------------------------
    localparam logic [7:0]  VAL_OFF   = 8'h00;
    localparam logic [7:0]  VAL_ON    = 8'hFF;
    localparam logic [15:0] RST_PULL  = 16'h044C;
    localparam logic [15:0] RST_HOLD  = 16'h01F4;
    localparam logic [7:0]  RST_PRELD = 8'h64;
    localparam logic [15:0] RST_TMO   = 16'h0384;
    localparam logic [7:0]  RST_VTYPE = 8'h00;
    localparam logic [15:0] CUR_MIN   = 16'h0064;
    localparam logic [15:0] CUR_MAX   = 16'h07D0;
    localparam logic [15:0] TMO_MAX   = 16'h03E8;
    localparam logic [6:0]  DUTY_FULL = 7'h64;
    localparam logic [15:0] OVERCUR   = 16'h09C4;
    localparam logic [1:0]  HTRANS_NS = 2'h2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_PS         = 1000000000;
    localparam int MS_CYC_DEF    = MS_PS / CLK_PERIOD_PS;
    localparam int PRELOAD_MS    = 120;
    localparam int PULL_MS       = 1880;
    localparam int HOLD_AT_MS    = PRELOAD_MS + PULL_MS;
    localparam int TMO_UNIT_MS   = 10;
    localparam int STILL_MS      = 100;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_ONROAD  = 3'b000,
        ST_STEP1   = 3'b001,
        ST_STEP2   = 3'b010,
        ST_OFFROAD = 3'b011,
        ST_SAFE    = 3'b100
    } csd_state_t;

    typedef struct packed {
        logic [7:0]  presence;
        logic [7:0]  mode;
        logic [15:0] pull;
        logic [15:0] hold;
        logic [7:0]  preload;
        logic [15:0] timeout;
        logic [7:0]  vtype;
    } csd_cfg_t;

    typedef struct packed {
        logic       sel;
        logic       wr;
        logic [7:0] addr;
    } csd_aph_t;

    typedef struct packed {
        csd_state_t  st;
        csd_cfg_t    cfg;
        csd_aph_t    aph;
        logic [31:0] rdata;
        logic [31:0] div;
        logic [11:0] act_ms;
        logic [15:0] chk_ms;
        logic [6:0]  duty;
        logic [6:0]  pwm_cnt;
        logic        pwm;
        logic        spool_cmd;
        logic        ehs_en;
        logic        safe;
    } csd_regs_t;

endpackage

// File: rtl/csd_top.sv
// Cut-off solenoid PWM driver, current monitor and off-road valve check
`timescale 1ns/1ps
module csd_top #(
    parameter int MS_CYC = csd_pkg::MS_CYC_DEF
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] coil_current_ma,
    input  wire logic        offroad_req,
    input  wire logic        spool_at_target,
    input  wire logic        spool_moved,
    output logic             sol_pwm,
    output logic             spool_cmd,
    output logic             ehs_enable,
    output logic             safe_state
);

    csd_pkg::csd_regs_t r_ff;
    csd_pkg::csd_regs_t nxt_r;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    function automatic logic in_cur(input logic [15:0] v);
        in_cur = (v >= csd_pkg::CUR_MIN) && (v <= csd_pkg::CUR_MAX);
    endfunction

    function automatic logic [31:0] rd_word(
        input csd_pkg::csd_regs_t r,
        input logic [7:0]         a
    );
        rd_word = 32'h0000_0000;
        case (a)
            csd_pkg::A_PRES:  rd_word[7:0]  = r.cfg.presence;
            csd_pkg::A_MODE:  rd_word[7:0]  = r.cfg.mode;
            csd_pkg::A_PULL:  rd_word[15:0] = r.cfg.pull;
            csd_pkg::A_HOLD:  rd_word[15:0] = r.cfg.hold;
            csd_pkg::A_PRELD: rd_word[7:0]  = r.cfg.preload;
            csd_pkg::A_TMO:   rd_word[15:0] = r.cfg.timeout;
            csd_pkg::A_VTYPE: rd_word[7:0]  = r.cfg.vtype;
            csd_pkg::A_STAT:
            begin
                rd_word[2:0]   = r.st;
                rd_word[3]     = r.safe;
                rd_word[4]     = r.ehs_en;
                rd_word[5]     = r.spool_cmd;
                rd_word[14:8]  = r.duty;
                rd_word[27:16] = r.act_ms;
            end
            default:          rd_word = 32'h0000_0000;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    logic        ms_tick;
    logic        energize;
    logic        closed_loop;
    logic        preload_phase;
    logic        hold_phase;
    logic        fault;
    logic [15:0] setpoint;
    logic [15:0] tmo_ms;
    logic [7:0]  wa;

    always_comb
    begin
        nxt_r = r_ff;
        fault = 1'b0;

        // Bus slave: address phase captured, write done in data phase
        wa = r_ff.aph.addr;
        if (r_ff.aph.sel && r_ff.aph.wr)
        begin
            case (wa)
                csd_pkg::A_PRES:  nxt_r.cfg.presence = hwdata[7:0];
                csd_pkg::A_MODE:  nxt_r.cfg.mode = hwdata[7:0];
                csd_pkg::A_PULL:
                begin
                    if (in_cur(hwdata[15:0]))
                    begin
                        nxt_r.cfg.pull = hwdata[15:0];
                    end
                end
                csd_pkg::A_HOLD:
                begin
                    if (in_cur(hwdata[15:0]))
                    begin
                        nxt_r.cfg.hold = hwdata[15:0];
                    end
                end
                csd_pkg::A_PRELD:
                begin
                    if (hwdata[7:0] <= {1'b0, csd_pkg::DUTY_FULL})
                    begin
                        nxt_r.cfg.preload = hwdata[7:0];
                    end
                end
                csd_pkg::A_TMO:
                begin
                    if (hwdata[15:0] <= csd_pkg::TMO_MAX)
                    begin
                        nxt_r.cfg.timeout = hwdata[15:0];
                    end
                end
                csd_pkg::A_VTYPE: nxt_r.cfg.vtype = hwdata[7:0];
                default:          nxt_r.cfg = r_ff.cfg;
            endcase
        end
        nxt_r.aph.sel = hsel && hready && (htrans == csd_pkg::HTRANS_NS);
        nxt_r.aph.wr = hwrite;
        nxt_r.aph.addr = {haddr[7:2], 2'b00};
        nxt_r.rdata = 32'h0000_0000;
        if (nxt_r.aph.sel && !hwrite)
        begin
            nxt_r.rdata = rd_word(r_ff, nxt_r.aph.addr);
        end

        // Millisecond time base
        ms_tick = (r_ff.div == 32'(MS_CYC - 1));
        nxt_r.div = ms_tick ? 32'h0000_0000 : r_ff.div + 32'h0000_0001;

        // Solenoid activation and phase timing since activation
        energize = ((r_ff.st == csd_pkg::ST_STEP1) ||
                    (r_ff.st == csd_pkg::ST_OFFROAD)) &&
                   (r_ff.cfg.presence == csd_pkg::VAL_ON);
        if (!energize)
        begin
            nxt_r.act_ms = 12'h000;
        end
        else if (ms_tick && (r_ff.act_ms < 12'(csd_pkg::HOLD_AT_MS)))
        begin
            nxt_r.act_ms = r_ff.act_ms + 12'h001;
        end
        preload_phase = r_ff.act_ms < 12'(csd_pkg::PRELOAD_MS);
        hold_phase = r_ff.act_ms >= 12'(csd_pkg::HOLD_AT_MS);
        setpoint = hold_phase ? r_ff.cfg.hold : r_ff.cfg.pull;
        closed_loop = (r_ff.cfg.mode != csd_pkg::VAL_OFF);

        // Duty selection, closed-loop step once per PWM period
        nxt_r.pwm_cnt = (r_ff.pwm_cnt == csd_pkg::DUTY_FULL - 7'h01) ?
                        7'h00 : r_ff.pwm_cnt + 7'h01;
        if (!energize)
        begin
            nxt_r.duty = 7'h00;
        end
        else if (!closed_loop)
        begin
            nxt_r.duty = csd_pkg::DUTY_FULL;
        end
        else if (preload_phase)
        begin
            nxt_r.duty = r_ff.cfg.preload[6:0];
        end
        else if (r_ff.pwm_cnt == 7'h00)
        begin
            if ((coil_current_ma < setpoint) &&
                (r_ff.duty < csd_pkg::DUTY_FULL))
            begin
                nxt_r.duty = r_ff.duty + 7'h01;
            end
            else if ((coil_current_ma > setpoint) && (r_ff.duty != 7'h00))
            begin
                nxt_r.duty = r_ff.duty - 7'h01;
            end
        end

        // Monitoring
        if (coil_current_ma > csd_pkg::OVERCUR)
        begin
            fault = 1'b1;
        end
        if ((r_ff.st == csd_pkg::ST_OFFROAD) && energize && hold_phase &&
            (coil_current_ma < {1'b0, r_ff.cfg.hold[15:1]}))
        begin
            fault = 1'b1;
        end
        if ((r_ff.cfg.presence != csd_pkg::VAL_OFF) &&
            (r_ff.cfg.presence != csd_pkg::VAL_ON))
        begin
            fault = 1'b1;
        end

        // Mode sequencing and off-road check
        tmo_ms = 16'(r_ff.cfg.timeout * 16'(csd_pkg::TMO_UNIT_MS));
        if (ms_tick && (r_ff.chk_ms != 16'hFFFF))
        begin
            nxt_r.chk_ms = r_ff.chk_ms + 16'h0001;
        end
        case (r_ff.st)
            csd_pkg::ST_ONROAD:
            begin
                nxt_r.chk_ms = 16'h0000;
                if (offroad_req)
                begin
                    if ((r_ff.cfg.presence == csd_pkg::VAL_OFF) ||
                        (r_ff.cfg.timeout == 16'h0000))
                    begin
                        nxt_r.st = csd_pkg::ST_OFFROAD;
                    end
                    else if (r_ff.cfg.vtype == csd_pkg::VAL_OFF)
                    begin
                        nxt_r.st = csd_pkg::ST_STEP1;
                    end
                end
            end
            csd_pkg::ST_STEP1:
            begin
                if (!offroad_req)
                begin
                    nxt_r.st = csd_pkg::ST_ONROAD;
                end
                else if (spool_at_target)
                begin
                    nxt_r.st = csd_pkg::ST_STEP2;
                    nxt_r.chk_ms = 16'h0000;
                end
                else if (r_ff.chk_ms >= tmo_ms)
                begin
                    fault = 1'b1;
                end
            end
            csd_pkg::ST_STEP2:
            begin
                if (!offroad_req)
                begin
                    nxt_r.st = csd_pkg::ST_ONROAD;
                end
                else if (spool_moved)
                begin
                    fault = 1'b1;
                end
                else if (r_ff.chk_ms >= 16'(csd_pkg::STILL_MS))
                begin
                    nxt_r.st = csd_pkg::ST_OFFROAD;
                end
            end
            csd_pkg::ST_OFFROAD:
            begin
                if (!offroad_req)
                begin
                    nxt_r.st = csd_pkg::ST_ONROAD;
                end
            end
            csd_pkg::ST_SAFE:
            begin
                nxt_r.st = csd_pkg::ST_SAFE;
            end
            default:
            begin
                nxt_r.st = csd_pkg::ST_SAFE;
            end
        endcase
        if (fault || r_ff.safe)
        begin
            nxt_r.st = csd_pkg::ST_SAFE;
            nxt_r.duty = 7'h00;
        end

        nxt_r.safe = (nxt_r.st == csd_pkg::ST_SAFE);
        nxt_r.pwm = (nxt_r.pwm_cnt < nxt_r.duty);
        nxt_r.spool_cmd = (nxt_r.st == csd_pkg::ST_STEP1) ||
                          (nxt_r.st == csd_pkg::ST_STEP2);
        nxt_r.ehs_en = (nxt_r.st == csd_pkg::ST_OFFROAD);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            r_ff.st            <= csd_pkg::ST_ONROAD;
            r_ff.cfg.presence  <= csd_pkg::VAL_ON;
            r_ff.cfg.mode      <= csd_pkg::VAL_ON;
            r_ff.cfg.pull      <= csd_pkg::RST_PULL;
            r_ff.cfg.hold      <= csd_pkg::RST_HOLD;
            r_ff.cfg.preload   <= csd_pkg::RST_PRELD;
            r_ff.cfg.timeout   <= csd_pkg::RST_TMO;
            r_ff.cfg.vtype     <= csd_pkg::RST_VTYPE;
            r_ff.aph           <= '0;
            r_ff.rdata         <= 32'h0000_0000;
            r_ff.div           <= 32'h0000_0000;
            r_ff.act_ms        <= 12'h000;
            r_ff.chk_ms        <= 16'h0000;
            r_ff.duty          <= 7'h00;
            r_ff.pwm_cnt       <= 7'h00;
            r_ff.pwm           <= 1'b0;
            r_ff.spool_cmd     <= 1'b0;
            r_ff.ehs_en        <= 1'b0;
            r_ff.safe          <= 1'b0;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign hrdata     = r_ff.rdata;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign sol_pwm    = r_ff.pwm;
    assign spool_cmd  = r_ff.spool_cmd;
    assign ehs_enable = r_ff.ehs_en;
    assign safe_state = r_ff.safe;

endmodule

// File: sim/csd_chk_assertions.sv
// Port-level checker of the cut-off solenoid driver
`timescale 1ns/1ps
module csd_chk #(
    parameter int MS_CYC = 20
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic [15:0] coil_current_ma,
    input wire logic        offroad_req,
    input wire logic        sol_pwm,
    input wire logic        spool_cmd,
    input wire logic        ehs_enable,
    input wire logic        safe_state
);
    // A tick may land just after entry, so allow one millisecond of slack
    localparam int STILL_CYC = (csd_pkg::STILL_MS - 1) * MS_CYC - 2;
    logic [31:0] still_ff;
    logic [31:0] nxt_still;

    // Length of the current run of commanded spool with coil dark
    always_comb
    begin
        nxt_still = (spool_cmd && !sol_pwm) ? still_ff + 32'h1 : 32'h0;
    end
    always_ff @(posedge sys_clk)
    begin
        still_ff <= rst_n ? nxt_still : 32'h0;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_rd_idle: assert property (
        !(hsel && hready && htrans == csd_pkg::HTRANS_NS && !hwrite)
        |=> hrdata == 32'h0) else $error("read data outside data phase");
    a_overcur_safe: assert property (
        coil_current_ma > csd_pkg::OVERCUR && !safe_state
        |=> safe_state && !sol_pwm) else $error("overcurrent ignored");
    a_safe_hold: assert property (
        safe_state |=> safe_state) else $error("safe state released");
    a_safe_dark: assert property (
        safe_state |-> !sol_pwm && !ehs_enable && !spool_cmd)
        else $error("drive active in safe state");
    a_onroad_dark: assert property (
        !offroad_req [*4] |-> !sol_pwm) else $error("coil driven on-road");
    a_onroad_exit: assert property (
        !offroad_req [*3] |-> !ehs_enable && !spool_cmd)
        else $error("steering left enabled on-road");
    a_ehs_cause: assert property (
        $rose(ehs_enable) |-> $past(offroad_req) && !safe_state)
        else $error("steering enabled without request");
    a_still_win: assert property (
        $rose(ehs_enable) && $past(spool_cmd) |-> $past(still_ff) >= STILL_CYC)
        else $error("still window cut short");
endmodule

bind csd_top csd_chk #(.MS_CYC(MS_CYC)) csd_chk_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .coil_current_ma(coil_current_ma), .offroad_req(offroad_req),
    .sol_pwm(sol_pwm), .spool_cmd(spool_cmd), .ehs_enable(ehs_enable),
    .safe_state(safe_state)
);

// File: sim/csd_coil.sv
// Behavioural solenoid coil and main spool seen from the driver
`timescale 1ns/1ps
module csd_coil (
    input  wire logic        sys_clk,
    input  wire logic        sol_pwm,
    input  wire logic        spool_cmd,
    input  wire logic        stuck,
    input  wire logic        leak,
    input  wire logic        fault,
    input  wire logic [15:0] fault_ma,
    output logic      [15:0] coil_current_ma,
    output logic             spool_at_target,
    output logic             spool_moved
);
    logic [31:0] acc = 32'h0;

    // Coil current lags the PWM average, 2200 mA at full duty
    always @(posedge sys_clk)
    begin
        acc <= acc + (sol_pwm ? 32'h55F0 : 32'h0) - acc / 32'h3E8;
        spool_at_target <= spool_cmd && !stuck && acc / 32'h2710 > 32'h12C;
        spool_moved <= spool_cmd && leak && !sol_pwm;
    end
    initial
    begin
        spool_at_target = 1'b0;
        spool_moved = 1'b0;
    end
    assign coil_current_ma = fault ? fault_ma : 16'(acc / 32'h2710);
endmodule

// File: sim/cutoff_solenoid_driver_monitor_tb.sv
// Self-checking bench of the cut-off solenoid driver
`timescale 1ns/1ps
module cutoff_solenoid_driver_monitor_tb;
    logic        sys_clk;
    logic        rst_n;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [15:0] coil_current_ma;
    logic        offroad_req;
    logic        spool_at_target;
    logic        spool_moved;
    logic        sol_pwm;
    logic        spool_cmd;
    logic        ehs_enable;
    logic        safe_state;
    logic        stuck;
    logic        leak;
    logic        fault;
    logic [15:0] fault_ma;
    logic [31:0] rv;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          n;
    logic [7:0]  wa [10] = '{csd_pkg::A_PULL, csd_pkg::A_PULL,
        csd_pkg::A_HOLD, csd_pkg::A_PULL, csd_pkg::A_PULL, csd_pkg::A_HOLD,
        csd_pkg::A_PRELD, csd_pkg::A_PRELD, csd_pkg::A_TMO, csd_pkg::A_TMO};
    logic [15:0] wv [10] = '{16'h07D1, 16'h0063, 16'h07D0, 16'h0064,
        16'h044C, 16'h01F4, 16'h0065, 16'h003C, 16'h03E9, 16'h000A};
    logic [15:0] we [10] = '{16'h044C, 16'h044C, 16'h07D0, 16'h0064,
        16'h044C, 16'h01F4, 16'h0064, 16'h003C, 16'h0384, 16'h000A};

    csd_top #(.MS_CYC(10)) csd_top_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .coil_current_ma(coil_current_ma),
        .offroad_req(offroad_req), .spool_at_target(spool_at_target),
        .spool_moved(spool_moved), .sol_pwm(sol_pwm),
        .spool_cmd(spool_cmd), .ehs_enable(ehs_enable),
        .safe_state(safe_state));
    csd_coil csd_coil_i (
        .sys_clk(sys_clk), .sol_pwm(sol_pwm), .spool_cmd(spool_cmd),
        .stuck(stuck), .leak(leak), .fault(fault), .fault_ma(fault_ma),
        .coil_current_ma(coil_current_ma),
        .spool_at_target(spool_at_target), .spool_moved(spool_moved));

    // ------------------------------------------------------------
    // Bus access and comparison
    // ------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic bad(input logic [31:0] g);
        n_mismatch++;
        $display("[FAIL] %0t unexpected %h", $time, g);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
            bad(g);
    endtask
    task automatic chk_rng(input logic [15:0] g, input logic [15:0] lo,
                           input logic [15:0] hi);
        samples_checked++;
        if ((^g === 1'bx) || g < lo || g > hi)
            bad({16'h0, g});
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        htrans <= csd_pkg::HTRANS_NS;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rv = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rv & m, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rst_seq;
        offroad_req <= 1'b0;
        stuck <= 1'b0;
        leak <= 1'b0;
        fault <= 1'b0;
        rst_n <= 1'b0;
        cyc(5);
        rst_n <= 1'b1;
    endtask
    task automatic give_verdict;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        {rst_n, hwrite, offroad_req, stuck, leak, fault} = 6'h0;
        {haddr, hwdata, htrans, fault_ma} = 82'h0;
        rst_seq();
        rd(csd_pkg::A_PRES, 32'hFFFFFFFF, 32'hFF);
        rd(csd_pkg::A_MODE, 32'hFFFFFFFF, 32'hFF);
        rd(csd_pkg::A_VTYPE, 32'hFFFFFFFF, 32'h0);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'hFFFFFFFF, 32'h0);
        chk(hresp, 1'b0);
        wr(csd_pkg::A_STAT, 32'hFFFFFFFF);
        rd(csd_pkg::A_STAT, 32'h7F3F, 32'h0);
        for (int i = 0; i < 10; i++)
        begin
            wr(wa[i], {16'h0, wv[i]});
            rd(wa[i], 32'hFFFFFFFF, {16'h0, we[i]});
        end
        // Closed loop with a passing spool check
        offroad_req <= 1'b1;
        cyc(3);
        rd(csd_pkg::A_STAT, 32'h3F, 32'h21);
        cyc(400);
        rd(csd_pkg::A_STAT, 32'h3F, 32'h22);
        chk(sol_pwm, 1'b0);
        cyc(650);
        chk(ehs_enable, 1'b0);
        cyc(400);
        rd(csd_pkg::A_STAT, 32'h3F, 32'h13);
        rd(csd_pkg::A_STAT, 32'h7F00, 32'h3C00);
        cyc(17000);
        chk_rng(coil_current_ma, 16'h03B6, 16'h04E2);
        cyc(8000);
        chk_rng(coil_current_ma, 16'h015E, 16'h028A);
        rd(csd_pkg::A_STAT, 32'h0FFF0000, 32'h07D00000);
        fault <= 1'b1;
        cyc(3);
        chk(safe_state, 1'b1);
        fault <= 1'b0;
        cyc(200);
        chk({safe_state, sol_pwm, ehs_enable}, 32'h4);
        // Spool never reaches the deadband point
        rst_seq();
        wr(csd_pkg::A_TMO, 32'h2);
        stuck <= 1'b1;
        offroad_req <= 1'b1;
        cyc(150);
        chk(safe_state, 1'b0);
        cyc(100);
        chk(safe_state, 1'b1);
        // Spool moves with the coil off
        rst_seq();
        wr(csd_pkg::A_TMO, 32'hA);
        leak <= 1'b1;
        offroad_req <= 1'b1;
        cyc(450);
        chk({safe_state, ehs_enable}, 32'h2);
        // On-off drive, bypassed check, overcurrent
        rst_seq();
        wr(csd_pkg::A_MODE, 32'h0);
        wr(csd_pkg::A_TMO, 32'h0);
        offroad_req <= 1'b1;
        cyc(5);
        chk(ehs_enable, 1'b1);
        n = 0;
        repeat (300)
        begin
            @(posedge sys_clk);
            n += sol_pwm;
        end
        chk(n, 32'h12C);
        fault_ma <= csd_pkg::OVERCUR;
        fault <= 1'b1;
        cyc(5);
        chk(safe_state, 1'b0);
        fault_ma <= 16'h09C5;
        cyc(2);
        chk({safe_state, sol_pwm}, 32'h2);
        // Valve type and presence settings
        rst_seq();
        wr(csd_pkg::A_VTYPE, 32'h1);
        offroad_req <= 1'b1;
        cyc(300);
        rd(csd_pkg::A_STAT, 32'h3F, 32'h0);
        offroad_req <= 1'b0;
        wr(csd_pkg::A_VTYPE, 32'h0);
        wr(csd_pkg::A_PRES, 32'h0);
        offroad_req <= 1'b1;
        cyc(20);
        rd(csd_pkg::A_STAT, 32'h3F, 32'h13);
        chk(sol_pwm, 1'b0);
        offroad_req <= 1'b0;
        cyc(4);
        chk(ehs_enable, 1'b0);
        wr(csd_pkg::A_PRES, 32'h7F);
        cyc(3);
        chk(safe_state, 1'b1);
        give_verdict();
    end
endmodule
